// >>> shared/afe_ctl_pkg.sv
// constants for the converter control word decoder
// assumes a single 10 MHz clock; the serial link pins are sampled into it
package afe_ctl_pkg;
	localparam int word_w = 16;
	// ----------------------------------------
	// control word field positions
	// ----------------------------------------
	localparam int bit_input_sel = 1;
	localparam int bit_rx_gain = 2;
	localparam int bit_over_lo = 3;
	localparam int bit_over_hi = 5;
	localparam int bit_atten_lo = 6;
	localparam int bit_atten_hi = 7;
	localparam int bit_m_lo = 8;
	localparam int bit_q_lo = 9;
	localparam int bit_q_hi = 11;
	localparam int bit_fac0 = 12;
	localparam int bit_fac1 = 13;
	localparam int bit_fac2 = 14;
	localparam int bit_fac3 = 15;
	localparam int bit_mode_lsb = 0;
	// reset value: m bit and q0 set, all else clear
	localparam logic [15:0] ctl_reset = 16'h0300;
	// ----------------------------------------
	// decoded values
	// ----------------------------------------
	// oversampling ratio, 0 marks a reserved code
	localparam logic [7:0] over_160 = 8'ha0;
	localparam logic [7:0] over_192 = 8'hc0;
	localparam logic [7:0] over_64 = 8'h40;
	localparam logic [7:0] over_96 = 8'h60;
	localparam logic [7:0] over_128 = 8'h80;
	localparam logic [7:0] over_rsvd = 8'h00;
	// q divider in half steps (value times two)
	localparam logic [4:0] q_base_whole = 5'h0a;
	localparam logic [4:0] q_base_half = 5'h09;
	localparam logic [4:0] q_step = 5'h02;
	// m divider, 0 marks reserved
	localparam logic [2:0] m_3 = 3'h3;
	localparam logic [2:0] m_4 = 3'h4;
	localparam logic [2:0] m_1 = 3'h1;
	localparam logic [2:0] m_2 = 3'h2;
	localparam logic [2:0] m_rsvd = 3'h0;
	// attenuation codes
	localparam logic [1:0] att_mute = 2'h0;
	localparam logic [1:0] att_minus6 = 2'h2;
	localparam logic [1:0] att_zero = 2'h3;
	localparam logic [1:0] att_rsvd = 2'h1;
	typedef enum logic [1:0] {
		data_only = 2'b00,
		soft_ctl = 2'b01,
		hard_ctl = 2'b11
	} xfer_mode_t;
endpackage : afe_ctl_pkg

// >>> verilog/afe_control_word_decoder.sv
// control word register of the analog front end and its field decode
// assumes the serial shifter delivers a whole received control word with a
// one-cycle strobe and flags whether it arrived in a secondary sync slot
// also holds the pin synchroniser and field register that it instances
//
// Notes on behaviour
// - a control word only loads when it arrives in the secondary frame sync slot.
// - after reset the device is in data-only mode with no control slot active.
// - input source select picks main input at 0 and auxiliary input at 1.
// - differential input gain is 0dB fixed common mode at 0, +6dB at 1.
// - single-ended input gain is -6dB at 0 and 0dB at 1.
// - oversampling code 000/001/101/110/111 gives 160/192/64/96/128, others reserved.
// - attenuation 00 mutes, 10 gives -6dB, 11 gives 0dB, 01 reserved.
// - bits 11..9 set Q from 5,6,7,8 then 4.5,5.5,6.5,7.5.
// - bits 13,12,8 set M as 3,4,1,2, unequal 13/12 reserved.
// - the field layout of the sixteen-bit word is fixed as decoded here.
// - in control modes a secondary sync occurs at mid-frame.
// - control transfer is on for pins 1x, or 00 with transmit lsb set.
// - words on the link are msb first two's complement.
// - master crystal mode fs equals input clock over M times Q times ratio.
module afe_control_word_decoder
	import afe_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic transfer_mode_pin0,
	input wire logic transfer_mode_pin1,
	input wire logic tx_word_strobe,
	input wire logic [afe_ctl_pkg::word_w-1:0] tx_word,
	input wire logic ctl_word_strobe,
	input wire logic ctl_word_secondary,
	input wire logic [afe_ctl_pkg::word_w-1:0] ctl_word_in,
	output logic [afe_ctl_pkg::word_w-1:0] converter_control_word,
	output logic control_slot_active,
	output logic input_source_select,
	output logic receive_gain_select,
	output logic [7:0] oversample_ratio,
	output logic [1:0] tx_atten,
	output logic [4:0] q_divider_x2,
	output logic [2:0] m_divider,
	output logic [3:0] factory_bits
);
	import afe_ctl_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// mode pins are static straps but may move; three stages, act on agreement
	// both pins reset to their low level, which selects data-only mode
	logic pin0_stable;
	logic pin1_stable;
	afe_pin_sync #(
		.idle_level(1'b0)
	) pin0_sync (
		.clk(clk),
		.rst(rst),
		.pin(transfer_mode_pin0),
		.level(pin0_stable)
	);

	afe_pin_sync #(
		.idle_level(1'b0)
	) pin1_sync (
		.clk(clk),
		.rst(rst),
		.pin(transfer_mode_pin1),
		.level(pin1_stable)
	);

	// ----------------------------------------
	// transfer mode
	// ----------------------------------------
	xfer_mode_t mode;
	xfer_mode_t next_mode;
	logic soft_lsb;
	// software mode latches the transmit word lsb each frame
	always_ff @(posedge clk) begin
		if (rst)
			soft_lsb <= 1'b0;
		else if (tx_word_strobe)
			soft_lsb <= tx_word[bit_mode_lsb];
	end
	always_comb begin
		if (pin1_stable)
			next_mode = hard_ctl;
		else if (!pin0_stable && soft_lsb)
			next_mode = soft_ctl;
		else
			next_mode = data_only;
	end
	always_ff @(posedge clk) begin
		if (rst)
			mode <= data_only;
		else
			mode <= next_mode;
	end
	wire ctl_enabled = (mode != data_only);

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// primary-slot words never reach the register, even in control modes
	wire load_ctl = ctl_word_strobe && ctl_word_secondary && ctl_enabled;
	always_ff @(posedge clk) begin
		if (rst)
			converter_control_word <= ctl_reset;
		else if (load_ctl)
			converter_control_word <= ctl_word_in;
	end
	always_ff @(posedge clk) begin
		if (rst)
			control_slot_active <= 1'b0;
		else
			control_slot_active <= (next_mode != data_only);
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	wire [15:0] next_word = load_ctl ? ctl_word_in : converter_control_word;
	wire [2:0] over_code = next_word[bit_over_hi:bit_over_lo];
	wire [1:0] att_code = next_word[bit_atten_hi:bit_atten_lo];
	wire [2:0] q_code = next_word[bit_q_hi:bit_q_lo];
	wire [2:0] m_code = {next_word[bit_fac1], next_word[bit_fac0], next_word[bit_m_lo]};
	logic [7:0] next_over;
	logic [2:0] next_m;
	always_comb begin
		unique case (over_code)
			3'h0: next_over = over_160;
			3'h1: next_over = over_192;
			3'h5: next_over = over_64;
			3'h6: next_over = over_96;
			3'h7: next_over = over_128;
			default: next_over = over_rsvd;
		endcase
	end
	always_comb begin
		unique case (m_code)
			3'h0: next_m = m_3;
			3'h1: next_m = m_4;
			3'h6: next_m = m_1;
			3'h7: next_m = m_2;
			default: next_m = m_rsvd;
		endcase
	end
	// q in half units so 4.5 .. 7.5 stay integer; fs math stays outside
	wire [4:0] q_base = q_code[2] ? q_base_half : q_base_whole;
	wire [4:0] q_offset = 5'(q_code[1:0]) * q_step;
	wire [4:0] next_q = 5'(q_base + q_offset);
	// reserved attenuation code is passed as is; treated as mute by the analog side
	wire [1:0] next_att = att_code;

	// ----------------------------------------
	// decoded output registers
	// ----------------------------------------
	// decode reads the word about to be stored, so fields move on the load edge
	wire next_input_sel = next_word[bit_input_sel];
	wire next_rx_gain = next_word[bit_rx_gain];
	wire [3:0] next_factory = {
		next_word[bit_fac3],
		next_word[bit_fac2],
		next_word[bit_fac1],
		next_word[bit_fac0]
	};

	// ----------------------------------------
	// source and gain
	// ----------------------------------------
	afe_field_reg #(
		.width(1),
		.reset_val(1'b0)
	) input_sel_reg (
		.clk(clk),
		.rst(rst),
		.d(next_input_sel),
		.q(input_source_select)
	);

	afe_field_reg #(
		.width(1),
		.reset_val(1'b0)
	) rx_gain_reg (
		.clk(clk),
		.rst(rst),
		.d(next_rx_gain),
		.q(receive_gain_select)
	);

	// ----------------------------------------
	// ratio and dividers
	// ----------------------------------------
	afe_field_reg #(
		.width(8),
		.reset_val(over_160)
	) over_reg (
		.clk(clk),
		.rst(rst),
		.d(next_over),
		.q(oversample_ratio)
	);

	// q kept doubled so the half steps stay integer
	afe_field_reg #(
		.width(5),
		.reset_val(5'(q_base_whole + q_step))
	) q_reg (
		.clk(clk),
		.rst(rst),
		.d(next_q),
		.q(q_divider_x2)
	);

	afe_field_reg #(
		.width(3),
		.reset_val(m_4)
	) m_reg (
		.clk(clk),
		.rst(rst),
		.d(next_m),
		.q(m_divider)
	);

	// ----------------------------------------
	// attenuation and test bits
	// ----------------------------------------
	// reserved attenuation code passes raw; the analog side treats it as mute
	afe_field_reg #(
		.width(2),
		.reset_val(att_mute)
	) att_reg (
		.clk(clk),
		.rst(rst),
		.d(next_att),
		.q(tx_atten)
	);

	afe_field_reg #(
		.width(4),
		.reset_val(4'h0)
	) factory_reg (
		.clk(clk),
		.rst(rst),
		.d(next_factory),
		.q(factory_bits)
	);
endmodule : afe_control_word_decoder

// ----------------------------------------
// pin synchroniser
// ----------------------------------------
// three stages; the output follows once the second and third agree, so a
// single metastable sample never reaches the mode logic
// reset at the idle level so no false mode change follows reset
module afe_pin_sync #(
	parameter logic idle_level = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic level
);
	logic [2:0] stages;
	wire agree = (stages[1] == stages[2]);
	always_ff @(posedge clk) begin
		if (rst)
			stages <= {3{idle_level}};
		else
			stages <= {stages[1:0], pin};
	end
	always_ff @(posedge clk) begin
		if (rst)
			level <= idle_level;
		else if (agree)
			level <= stages[2];
	end
endmodule : afe_pin_sync

// ----------------------------------------
// field register
// ----------------------------------------
// one flop stage per decoded field keeps every output straight off a flop
// width and reset value come from the field that it holds
module afe_field_reg #(
	parameter int width = 1,
	parameter logic [width-1:0] reset_val = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [width-1:0] d,
	output logic [width-1:0] q
);
	always_ff @(posedge clk) begin
		if (rst)
			q <= reset_val;
		else
			q <= d;
	end
endmodule : afe_field_reg

// >>> test/afe_host_model.sv
// host side of the serial link: hands whole control words to the decoder
// assumes the bench calls put just after a clock edge
module afe_host_model
	import afe_ctl_pkg::*;
(
	input wire logic clk,
	output logic ctl_word_strobe,
	output logic ctl_word_secondary,
	output logic [word_w-1:0] ctl_word_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{ctl_word_strobe, ctl_word_secondary, ctl_word_in} = 18'h0;
	end
	// one strobe per whole word, msb at bit 15; released lines show the inverse
	task automatic put(input logic [15:0] w, input logic sec);
		@(posedge clk);
		#1;
		{ctl_word_strobe, ctl_word_secondary, ctl_word_in} = {1'b1, sec, w};
		@(posedge clk);
		#1;
		{ctl_word_strobe, ctl_word_secondary, ctl_word_in} = {1'b0, ~sec, ~w};
	endtask : put
endmodule : afe_host_model

// >>> test/afe_ctl_checker.sv
// port checker of the control word decoder
// assumes one clock with a synchronous active high reset
module afe_ctl_checker
	import afe_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic transfer_mode_pin0,
	input wire logic transfer_mode_pin1,
	input wire logic ctl_word_strobe,
	input wire logic ctl_word_secondary,
	input wire logic [15:0] ctl_word_in,
	input wire logic [15:0] converter_control_word,
	input wire logic control_slot_active,
	input wire logic input_source_select,
	input wire logic receive_gain_select,
	input wire logic [7:0] oversample_ratio,
	input wire logic [1:0] tx_atten,
	input wire logic [4:0] q_divider_x2,
	input wire logic [2:0] m_divider,
	input wire logic [3:0] factory_bits
);
	wire logic [15:0] w = converter_control_word;
	wire logic [63:0] ov_tab = 64'h8060_4000_0000_c0a0;
	wire logic [11:0] m_tab = {3'h2, 3'h1, 3'h4, 3'h3};
	wire logic [1:0] m_idx = {w[13], w[8]};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	load_sec_a: assert property (ctl_word_strobe && ctl_word_secondary && control_slot_active
		&& $past(control_slot_active) |=> w == $past(ctl_word_in)) else $error("lost load");
	primary_keep_a: assert property (ctl_word_strobe && !ctl_word_secondary |=> $stable(w))
		else $error("primary word loaded");
	data_keep_a: assert property (!control_slot_active && !$past(control_slot_active)
		|=> $stable(w)) else $error("load in data mode");
	reset_val_a: assert property ($past(rst) |-> w == ctl_reset && !control_slot_active)
		else $error("bad reset state");
	sel_gain_a: assert property ({receive_gain_select, input_source_select} == w[2:1])
		else $error("bad select decode");
	over_a: assert property (oversample_ratio == ov_tab[w[5:3] * 8 +: 8])
		else $error("bad ratio");
	atten_fac_a: assert property (tx_atten == w[7:6] && factory_bits == w[15:12])
		else $error("bad field");
	q_div_a: assert property (q_divider_x2 == (w[11] ? 5'h09 : 5'h0a) + {w[10:9], 1'b0})
		else $error("bad q divider");
	m_div_a: assert property (m_divider == (w[13] ^ w[12] ? 3'h0 : m_tab[m_idx * 3 +: 3]))
		else $error("bad m divider");
	hard_pins_a: assert property (transfer_mode_pin1 [*8] |-> control_slot_active)
		else $error("control slot off");
	data_pins_a: assert property ((!transfer_mode_pin1 && transfer_mode_pin0) [*8]
		|-> !control_slot_active) else $error("control slot on");
	load_c: cover property (ctl_word_strobe && ctl_word_secondary && control_slot_active);
	primary_c: cover property (ctl_word_strobe && !ctl_word_secondary && control_slot_active);
	slot_rise_c: cover property ($rose(control_slot_active));
endmodule : afe_ctl_checker
bind afe_control_word_decoder afe_ctl_checker chk (.*);

// >>> test/afe_control_word_decoder_tb.sv
// self-checking bench of the control word decoder
// assumes the host model feeds control words; the bench drives the mode pins
module afe_control_word_decoder_tb;
	import afe_ctl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, transfer_mode_pin0 = 0, transfer_mode_pin1 = 0, tx_word_strobe = 0;
	logic [15:0] tx_word = 16'h0000, converter_control_word, ctl_word_in;
	logic ctl_word_strobe, ctl_word_secondary, control_slot_active;
	logic input_source_select, receive_gain_select;
	logic [7:0] oversample_ratio;
	logic [1:0] tx_atten;
	logic [4:0] q_divider_x2;
	logic [2:0] m_divider;
	logic [3:0] factory_bits;
	int err_count = 0, n_tests = 0, cyc = 0;
	afe_control_word_decoder dut (.*);
	afe_host_model host (.clk, .ctl_word_strobe, .ctl_word_secondary, .ctl_word_in);
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	// the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// pins pass a synchroniser, so wait a bounded time for the slot flag
	task automatic mode(input logic p1, input logic p0, input logic lsb, input logic exp);
		@(posedge clk);
		#1;
		{transfer_mode_pin1, transfer_mode_pin0, tx_word_strobe, tx_word} = {p1, p0, 1'b1, 15'h0, lsb};
		@(posedge clk);
		#1;
		tx_word_strobe = 0;
		for (int k = 0; k < 10 && control_slot_active !== exp; k++) @(posedge clk);
		@(posedge clk);
		#1;
		cmp(control_slot_active, exp);
	endtask : mode
	task automatic load(input logic [15:0] w, input logic sec, input logic [15:0] exp);
		host.put(w, sec);
		cmp(converter_control_word, exp);
	endtask : load
	task automatic dec(input logic [15:0] w, input logic [7:0] ov, input logic [2:0] m);
		cmp(input_source_select, w[1]);
		cmp(receive_gain_select, w[2]);
		cmp(oversample_ratio, ov);
		cmp(tx_atten, w[7:6]);
		cmp(q_divider_x2, w[11] ? 2 * w[10:9] + 9 : 2 * w[10:9] + 10);
		cmp(m_divider, m);
		cmp(factory_bits, w[15:12]);
	endtask : dec
	task automatic t_hard();
		logic [2:0] oc [8] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1, 3'h5};
		logic [7:0] ev [8] = '{8'ha0, 8'hc0, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'h40};
		logic [2:0] mx [4] = '{3'h3, 3'h4, 3'h1, 3'h2};
		logic [15:0] w;
		mode(1'b1, 1'b0, 1'b0, 1'b1);
		load(16'h0a38, 1'b0, ctl_reset);
		for (int i = 0; i < 8; i++) begin
			w = {2'h0, {2{i[1]}}, i[2:0], i[0], i[0] | i[1], i[0], oc[i], i[1], i[0], 1'b0};
			load(w, 1'b1, w);
			dec(w, ev[i], mx[i % 4]);
		end
		$display("hard mode test done");
	endtask : t_hard
	task automatic t_data();
		cmp(converter_control_word, ctl_reset);
		cmp(control_slot_active, 1'b0);
		mode(1'b0, 1'b0, 1'b0, 1'b0);
		load(16'h3fea, 1'b1, ctl_reset);
		$display("data mode test done");
	endtask : t_data
	task automatic t_soft();
		mode(1'b0, 1'b0, 1'b1, 1'b1);
		load(16'h3fea, 1'b1, 16'h3fea);
		dec(16'h3fea, 8'h40, 3'h2);
		mode(1'b0, 1'b1, 1'b1, 1'b0);
		load(16'h0300, 1'b1, 16'h3fea);
		$display("soft mode test done");
	endtask : t_soft
	// mid-run reset with soft control armed: must come back in data-only mode
	task automatic t_reset();
		mode(1'b0, 1'b0, 1'b1, 1'b1);
		@(posedge clk);
		#1;
		rst = 1;
		repeat (2) @(posedge clk);
		#1;
		rst = 0;
		cmp(converter_control_word, ctl_reset);
		cmp(control_slot_active, 1'b0);
		dec(ctl_reset, over_160, m_4);
		load(16'h3fea, 1'b1, ctl_reset);
		$display("reset test done");
	endtask : t_reset
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 0;
		t_data();
		t_hard();
		t_soft();
		t_reset();
		stop_test();
	end
endmodule : afe_control_word_decoder_tb
